//--- rtl/gsl_pkg.sv
`default_nettype none
package gsl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL      = 8'h02;
  localparam logic [7:0]  IDX_STATUS    = 8'h03;
  localparam logic [7:0]  IDX_HWIDTH    = 8'h04;
  localparam logic [7:0]  IDX_CURADDR   = 8'h05;
  localparam logic [7:0]  IDX_LINES     = 8'h06;
  localparam logic [7:0]  IDX_START     = 8'h0c;
  localparam logic [7:0]  IDX_EXTRA     = 8'h11;
  localparam logic [7:0]  IDX_LUTIDX    = 8'h15;
  localparam logic [7:0]  IDX_LUTDATA   = 8'h17;

  localparam int          ADDR_W        = 12;
  localparam int          WORD_ADDR_W   = 17;
  localparam int          LINES_W       = 10;
  localparam int          LUT_W         = 12;
  localparam int          LUT_DEPTH     = 256;

  // control fields
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_BPP_LSB  = 1;
  localparam logic [1:0]  BPP_1         = 2'h0;
  localparam logic [1:0]  BPP_2         = 2'h1;
  localparam logic [1:0]  BPP_4         = 2'h2;
  localparam logic [1:0]  BPP_8         = 2'h3;

  // status fields
  localparam int          STAT_RUN_BIT  = 0;
  localparam int          STAT_ERR_BIT  = 1;

  // lookup entry layout: red 11:8, green 7:4, blue 3:0
  localparam int          LUT_G_MSB     = 7;
  localparam int          LUT_G_LSB     = 4;

  // reset values
  localparam logic [1:0]  BPP_RST       = 2'h0;
  localparam logic [7:0]  HWIDTH_RST    = 8'h14;
  localparam logic [9:0]  LINES_RST     = 10'h0f0;
  localparam logic [7:0]  EXTRA_RST     = 8'h00;
  localparam logic [16:0] START_RST     = 17'h00000;

  function automatic logic [ADDR_W-1:0] reg_byte_addr(input logic [7:0] idx);
    reg_byte_addr = {2'h0, idx, 2'h0};
  endfunction
endpackage
`default_nettype wire

//--- rtl/gsl_fifo.sv
`default_nettype none
module gsl_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } gsl_fifo_st_t;

  gsl_fifo_st_t s_q;
  gsl_fifo_st_t s_d;
  logic         push;
  logic         pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    if (clr) begin
      s_d.wp  = '0;
      s_d.rp  = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/gsl_top.sv
// Function
// - Each gray level comes only from the green field of the chosen lookup entry.
// - Since only green is used, the output has exactly sixteen intensity levels.
// - Gray shade is not offered at 8 bpp and software must not select that depth.
// - At 1 bpp each byte gives eight pixels, bit 0 shows entry 0 and bit 1 entry 1.
// - At 1 bpp only the first two lookup entries are used, each holding any level.
// - At 2 bpp each byte gives four pixels, codes 00 to 11 pick entries 0 to 3.
// - At 2 bpp entries above the first four have no effect on the output.
// - At 4 bpp each byte gives two pixels, nibbles 0000 to 1111 pick entries 0 to 15.
// - An 8-bit value holds how many extra 16-bit words follow each scan line.
// - That value accepts any count from 0 to 255.
// - With the value at zero a line steps to the next by the visible width only.
// - The value never changes how many words are shown; the width setting does.
// - A word holds 16 pixels at 1 bpp, 8 at 2 bpp, 4 at 4 bpp and 2 at 8 bpp.
//
// Decided for this implementation: register access over APB.
`default_nettype none
module gsl_top #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                ce,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [gsl_pkg::ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                         pwdata,
  output logic [31:0]                              prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  output logic [gsl_pkg::WORD_ADDR_W-1:0]          mem_addr,
  output logic                                     mem_req,
  input  wire logic                                mem_ack,
  input  wire logic [15:0]                         mem_rdata,
  output logic [3:0]                               pix_gray,
  output logic                                     pix_valid,
  input  wire logic                                pix_ready
);
  import gsl_pkg::*;

  typedef struct packed {
    logic                                pready;
    logic                                pslverr;
    logic [31:0]                         prdata;
    logic                                en;
    logic [1:0]                          bpp;
    logic [7:0]                          hwidth;
    logic [LINES_W-1:0]                  lines;
    logic [WORD_ADDR_W-1:0]              start;
    logic [7:0]                          extra;
    logic [7:0]                          lut_idx;
    logic [LUT_DEPTH-1:0][LUT_W-1:0]     colour_lookup_table;
    logic                                run;
    logic                                cfg_err;
    logic                                req;
    logic [WORD_ADDR_W-1:0]              line_addr;
    logic [WORD_ADDR_W-1:0]              addr;
    logic [7:0]                          wcnt;
    logic [LINES_W-1:0]                  lcnt;
    logic [15:0]                         sh;
    logic [4:0]                          pcnt;
    logic [3:0]                          gray;
    logic                                pvalid;
  } gsl_top_st_t;

  gsl_top_st_t s_q;
  gsl_top_st_t s_d;

  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [15:0] f_out_data;
  logic        f_push;

  // pixels held by one memory word
  function automatic logic [4:0] px_per_word(input logic [1:0] b);
    case (b)
      BPP_1:   px_per_word = 5'h10;
      BPP_2:   px_per_word = 5'h08;
      BPP_4:   px_per_word = 5'h04;
      default: px_per_word = 5'h02;
    endcase
  endfunction

  // leading pixel field, zero-extended to a lookup index
  function automatic logic [7:0] px_code(input logic [15:0] w, input logic [1:0] b);
    case (b)
      BPP_1:   px_code = {7'h00, w[15]};
      BPP_2:   px_code = {6'h00, w[15:14]};
      default: px_code = {4'h0, w[15:12]};
    endcase
  endfunction

  function automatic logic [15:0] px_shift(input logic [15:0] w, input logic [1:0] b);
    case (b)
      BPP_1:   px_shift = {w[14:0], 1'b0};
      BPP_2:   px_shift = {w[13:0], 2'h0};
      default: px_shift = {w[11:0], 4'h0};
    endcase
  endfunction

  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    idx_hit = (a == reg_byte_addr(idx));
  endfunction

  gsl_fifo #(
    .W     (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .clr       (!s_q.run),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (mem_rdata),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  assign f_push      = s_q.req && mem_ack;
  assign f_out_ready = s_q.run && (s_q.pcnt == 5'h00);

  always_comb begin
    logic        access;
    logic        mapped;
    logic        wr_now;
    logic [31:0] rd;
    logic        go;
    logic [7:0]  code;
    logic [WORD_ADDR_W-1:0] next_line;
    access    = psel && penable;
    mapped    = 1'b0;
    wr_now    = 1'b0;
    rd        = 32'h00000000;
    go        = 1'b0;
    code      = 8'h00;
    next_line = '0;
    s_d       = s_q;

    // register bus: answer one cycle into the access phase
    case (1'b1)
      idx_hit(paddr, IDX_CTRL): begin
        mapped = 1'b1;
        rd     = {29'h0, s_q.bpp, s_q.en};
      end
      idx_hit(paddr, IDX_STATUS): begin
        mapped = 1'b1;
        rd     = {30'h0, s_q.cfg_err, s_q.run};
      end
      idx_hit(paddr, IDX_HWIDTH): begin
        mapped = 1'b1;
        rd     = {24'h0, s_q.hwidth};
      end
      idx_hit(paddr, IDX_CURADDR): begin
        mapped = 1'b1;
        rd     = {15'h0, s_q.line_addr};
      end
      idx_hit(paddr, IDX_LINES): begin
        mapped = 1'b1;
        rd     = {22'h0, s_q.lines};
      end
      idx_hit(paddr, IDX_START): begin
        mapped = 1'b1;
        rd     = {15'h0, s_q.start};
      end
      idx_hit(paddr, IDX_EXTRA): begin
        mapped = 1'b1;
        rd     = {24'h0, s_q.extra};
      end
      idx_hit(paddr, IDX_LUTIDX): begin
        mapped = 1'b1;
        rd     = {24'h0, s_q.lut_idx};
      end
      idx_hit(paddr, IDX_LUTDATA): begin
        mapped = 1'b1;
        rd     = {20'h0, s_q.colour_lookup_table[s_q.lut_idx]};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase

    s_d.pready = access && !s_q.pready;
    if (access && !s_q.pready) begin
      s_d.prdata  = pwrite ? 32'h00000000 : rd;
      s_d.pslverr = !mapped;
    end
    wr_now = access && s_q.pready && pwrite && !s_q.pslverr;
    if (wr_now) begin
      case (1'b1)
        idx_hit(paddr, IDX_CTRL): begin
          s_d.en  = pwdata[CTRL_EN_BIT];
          s_d.bpp = pwdata[CTRL_BPP_LSB +: 2];
        end
        idx_hit(paddr, IDX_HWIDTH):  s_d.hwidth  = pwdata[7:0];
        idx_hit(paddr, IDX_LINES):   s_d.lines   = pwdata[LINES_W-1:0];
        idx_hit(paddr, IDX_START):   s_d.start   = pwdata[WORD_ADDR_W-1:0];
        idx_hit(paddr, IDX_EXTRA):   s_d.extra   = pwdata[7:0];
        idx_hit(paddr, IDX_LUTIDX):  s_d.lut_idx = pwdata[7:0];
        idx_hit(paddr, IDX_LUTDATA): begin
          // auto-increment lets software stream a whole table
          s_d.colour_lookup_table[s_q.lut_idx] = pwdata[LUT_W-1:0];
          s_d.lut_idx = s_q.lut_idx + 8'h01;
        end
        default: begin
          s_d.lut_idx = s_q.lut_idx;
        end
      endcase
    end

    // gray shade has no 8 bpp form, so that depth is refused
    s_d.cfg_err = s_q.en && (s_q.bpp == BPP_8);
    go = s_q.en && (s_q.bpp != BPP_8) && (s_q.hwidth != 8'h00)
         && (s_q.lines != '0);
    // a fetch in flight must finish before a new run moves the address
    s_d.run = go && (s_q.run || !s_q.req);

    if (!go) begin
      // request stays up until memory answers, even when switched off
      s_d.req    = s_q.req && !mem_ack;
      s_d.pcnt   = 5'h00;
      s_d.pvalid = 1'b0;
    end else if (!s_q.run && s_q.req) begin
      s_d.req = !mem_ack;
    end else if (!s_q.run) begin
      s_d.line_addr = s_q.start;
      s_d.addr      = s_q.start;
      s_d.wcnt      = 8'h00;
      s_d.lcnt      = '0;
    end else begin
      // fetch: one read outstanding, raised only with room in the fifo
      if (f_push) begin
        s_d.req = 1'b0;
        // visible words per line come from the width alone
        if (s_q.wcnt == s_q.hwidth - 8'h01) begin
          s_d.wcnt  = 8'h00;
          next_line = s_q.line_addr + WORD_ADDR_W'(s_q.hwidth)
                      + WORD_ADDR_W'(s_q.extra);
          if (s_q.lcnt == s_q.lines - 1'b1) begin
            s_d.lcnt      = '0;
            s_d.line_addr = s_q.start;
            s_d.addr      = s_q.start;
          end else begin
            s_d.lcnt      = s_q.lcnt + 1'b1;
            s_d.line_addr = next_line;
            s_d.addr      = next_line;
          end
        end else begin
          s_d.wcnt = s_q.wcnt + 8'h01;
          s_d.addr = s_q.addr + 1'b1;
        end
      end else if (!s_q.req && f_in_ready) begin
        s_d.req = 1'b1;
      end

      // unpack: pixel stage stalls on the panel side
      if (s_q.pvalid && pix_ready) begin
        s_d.pvalid = 1'b0;
      end
      if (s_q.pcnt != 5'h00 && (!s_q.pvalid || pix_ready)) begin
        code       = px_code(s_q.sh, s_q.bpp);
        s_d.gray   = s_q.colour_lookup_table[code][LUT_G_MSB:LUT_G_LSB];
        s_d.pvalid = 1'b1;
        s_d.sh     = px_shift(s_q.sh, s_q.bpp);
        s_d.pcnt   = s_q.pcnt - 5'h01;
      end else if (f_out_valid && f_out_ready) begin
        // low byte of a word is the earlier byte on screen
        s_d.sh   = {f_out_data[7:0], f_out_data[15:8]};
        s_d.pcnt = px_per_word(s_q.bpp);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.bpp    <= BPP_RST;
      s_q.hwidth <= HWIDTH_RST;
      s_q.lines  <= LINES_RST;
      s_q.extra  <= EXTRA_RST;
      s_q.start  <= START_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign mem_addr  = s_q.addr;
  assign mem_req   = s_q.req;
  assign pix_gray  = s_q.gray;
  assign pix_valid = s_q.pvalid;
endmodule
`default_nettype wire

//--- verif/gsl_chk.sv
`default_nettype none
module gsl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [16:0] mem_addr,
  input wire logic        mem_req,
  input wire logic        mem_ack,
  input wire logic [3:0]  pix_gray,
  input wire logic        pix_valid,
  input wire logic        pix_ready
);
  logic wr_land;
  // a landed write may switch the block off, which drops a waiting pixel
  assign wr_land = psel && penable && pwrite && pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait");
  a_pready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_pready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  a_unaligned_refused: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  a_fetch_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped early");
  a_fetch_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("fetch request kept after ack");
  a_pixel_held: assert property (pix_valid && !pix_ready && !wr_land && !$past(wr_land)
    |=> pix_valid && $stable(pix_gray))
    else $error("pixel changed while stalled");
  c_apb_write: cover property (psel && penable && pwrite && pready);
  c_fetch: cover property (mem_req && mem_ack);
  c_pixel: cover property (pix_valid && pix_ready);
endmodule
bind gsl_top gsl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_addr(mem_addr), .mem_req(mem_req), .mem_ack(mem_ack), .pix_gray(pix_gray),
  .pix_valid(pix_valid), .pix_ready(pix_ready));
`default_nettype wire

//--- verif/gsl_mem_model.sv
`default_nettype none
module gsl_mem_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        slow,
  input wire logic        mem_req,
  input wire logic [16:0] mem_addr,
  output logic            mem_ack,
  output logic [15:0]     mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0;
    end else if (mem_req && !mem_ack) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q >= (slow ? 3'h3 : 3'h0)) begin
        // high byte tags the word address so stepping shows in the data
        mem_ack <= 1'b1;
        mem_rdata <= {mem_addr[7:0], 8'h1b};
        cnt_q <= 3'h0;
      end
    end else begin
      // data not held once the answer is gone
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt_q <= 3'h0;
    end
  end
endmodule
`default_nettype wire

//--- verif/gsl_top_tb_top.sv
`default_nettype none
module gsl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gsl_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pix_ready = 0, stall = 1, slow = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd_d;
  logic        pready, pslverr, mem_req, mem_ack, pix_valid, rd_e;
  logic [16:0] mem_addr;
  logic [15:0] mem_rdata;
  logic [3:0]  pix_gray;
  logic [16:0] aq[$];
  int          n_fail = 0, n_checks = 0, cyc = 0, i;

  gsl_top #(.FIFO_DEPTH(16)) uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .pix_gray(pix_gray), .pix_valid(pix_valid),
    .pix_ready(pix_ready));
  gsl_mem_model mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    pix_ready <= stall ? 1'b0 : ~pix_ready;
    if (mem_req === 1'b1 && mem_ack === 1'b1) aq.push_back(mem_addr);
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic s_regs;
    apb(0, ba(IDX_EXTRA), 0); chk("extra reset", 32'h0, rd_d);
    apb(1, ba(IDX_EXTRA), 32'hff); apb(0, ba(IDX_EXTRA), 0); chk("extra max", 32'hff, rd_d);
    apb(0, 12'h3fc, 0); chk("unmapped err", 32'h1, {31'h0, rd_e});
    chk("unmapped data", 32'h0, rd_d);
    apb(1, 12'h045, 32'h1); chk("unaligned err", 32'h1, {31'h0, rd_e});
    apb(1, ba(IDX_CTRL), {29'h0, BPP_8, 1'b1});
    apb(0, ba(IDX_STATUS), 0); chk("8bpp status", 32'h2, rd_d);
    apb(1, ba(IDX_CTRL), 0);
  endtask
  task automatic s_gray(input logic [1:0] code, input int b);
    logic [15:0] s;
    logic [3:0]  c;
    s = 16'h1b00;  // word 0 holds 16'h001b; low byte is shown first
    apb(1, ba(IDX_CTRL), {29'h0, code, 1'b1});
    for (int k = 0; k < 16 / b; k++) begin
      do @(posedge pclk); while (!(pix_valid === 1'b1 && pix_ready === 1'b1));
      c = 4'((s >> (16 - (k + 1) * b)) & ((1 << b) - 1));
      chk("gray", {28'h0, ~c}, {28'h0, pix_gray});
    end
    apb(1, ba(IDX_CTRL), 0);
  endtask
  task automatic s_pitch(input logic [7:0] extra, input logic [16:0] e [4]);
    int s1;
    apb(1, ba(IDX_EXTRA), {24'h0, extra});
    aq.delete();
    stall <= 1'b1;
    apb(1, ba(IDX_CTRL), {29'h0, BPP_4, 1'b1});
    repeat (200) @(posedge pclk);
    s1 = aq.size();
    repeat (50) @(posedge pclk);
    chk("fill stops", s1, aq.size());
    chk("fill depth", 32'h1, {31'h0, s1 >= 16});
    stall <= 1'b0;
    apb(1, ba(IDX_CTRL), 0);
    for (int k = 0; k < 5; k++) chk("line addr", {15'h0, e[k % 4]}, {15'h0, aq[k]});
  endtask
  task automatic s_mono;
    logic [15:0] s;
    s = 16'h1b00;
    apb(1, ba(IDX_LUTIDX), 0);
    // black and white as software is advised to load them
    apb(1, ba(IDX_LUTDATA), 32'h000);
    apb(1, ba(IDX_LUTDATA), 32'h0f0);
    apb(1, ba(IDX_CTRL), {29'h0, BPP_1, 1'b1});
    for (int k = 0; k < 16; k++) begin
      do @(posedge pclk); while (!(pix_valid === 1'b1 && pix_ready === 1'b1));
      chk("mono", {28'h0, {4{s[15-k]}}}, {28'h0, pix_gray});
    end
    apb(1, ba(IDX_CTRL), 0);
  endtask
  task print_verdict;
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    apb(1, ba(IDX_LUTIDX), 0);
    // red and blue at full scale so any leak of them shows
    for (i = 0; i < 16; i++) apb(1, ba(IDX_LUTDATA), {20'h0, 4'hf, ~4'(i), 4'hf});
    apb(1, ba(IDX_HWIDTH), 32'h1);
    apb(1, ba(IDX_LINES), 32'h1);
    apb(1, ba(IDX_START), 32'h0);
    stall <= 1'b0;
    s_gray(BPP_1, 1);
    s_gray(BPP_2, 2);
    s_gray(BPP_4, 4);
    // two lines of two words stay far inside display memory
    apb(1, ba(IDX_HWIDTH), 32'h2);
    apb(1, ba(IDX_LINES), 32'h2);
    apb(1, ba(IDX_START), 32'h10);
    slow <= 1'b1;
    s_pitch(8'h03, '{17'h10, 17'h11, 17'h15, 17'h16});
    s_pitch(8'h00, '{17'h10, 17'h11, 17'h12, 17'h13});
    apb(1, ba(IDX_HWIDTH), 32'h1);
    apb(1, ba(IDX_LINES), 32'h1);
    apb(1, ba(IDX_START), 32'h0);
    s_mono();
    print_verdict();
  end
endmodule
`default_nettype wire
